// ---- pkg/branch_cmp_pkg.sv ----
package branch_cmp_pkg;

  // ************************************************************
  // condition code bit positions
  // ************************************************************
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_H = 5;

  // ************************************************************
  // software register offsets and reset values
  // ************************************************************
  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_SP = 4'h1;
  localparam logic [3:0] REG_ACC_A = 4'h2;
  localparam logic [3:0] REG_ACC_B = 4'h3;
  localparam logic [3:0] REG_IDX = 4'h4;
  localparam logic [3:0] REG_CC = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] CC_RESET = 8'h00;
  localparam logic [7:0] CLEAR_VALUE = 8'h00;

  // ************************************************************
  // operations, targets, sequencer states
  // ************************************************************
  typedef enum logic [3:0] {
    branch_lower_or_same = 4'h0,
    branch_signed_less = 4'h1,
    branch_minus = 4'h2,
    branch_not_equal = 4'h3,
    branch_plus = 4'h4,
    branch_always = 4'h5,
    branch_never = 4'h6,
    branch_overflow_clear = 4'h7,
    branch_overflow_set = 4'h8,
    branch_to_subroutine = 4'h9,
    clear_operand = 4'hA,
    compare_byte = 4'hB,
    compare_word = 4'hC,
    ones_complement_op = 4'hD
  } op_t;

  typedef enum logic [2:0] {
    tgt_acc_a = 3'h0,
    tgt_acc_b = 3'h1,
    tgt_mem = 3'h2,
    tgt_double_acc = 3'h3,
    tgt_index = 3'h4
  } tgt_t;

  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_wait = 3'h1,
    st_fetch = 3'h2,
    st_exec = 3'h3,
    st_push_hi = 3'h4,
    st_jump = 3'h5
  } state_t;

  // one instruction request
  typedef struct packed {
    op_t op;
    logic long_form;
    tgt_t tgt;
    logic [15:0] effective_address;
    logic signed [2:0] idx_step;
  } cmd_t;

endpackage : branch_cmp_pkg

// ---- core/branch_compare_flag_unit.sv ----
// Summary of operation
// - lower-or-same taken when carry or zero set
// - signed-less taken when negative xor overflow
// - minus taken when negative set
// - not-equal taken when zero clear
// - plus taken when negative clear
// - always branch adds offset to counter
// - never branch fetches offset, no jump
// - subroutine branch pushes low, high, jumps
// - overflow-clear taken when overflow clear
// - overflow-set taken when overflow set
// - branches never alter condition flags
// - clear writes zero, N V C clear, Z set
// - clear of memory reads address first
// - byte compare sets NZVC, writes nothing
// - compare carry is inverted carry out
// - word compare big-endian, keeps half-carry
// - word compare only steps index register
// - complement inverts, sets NZ, V=0, C=1
`timescale 1ns/100ps
`default_nettype none
module branch_compare_flag_unit (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // software register port
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  // instruction request
  input wire logic cmd_start,
  input wire branch_cmp_pkg::cmd_t cmd_in,
  output logic busy,
  output logic done,
  // memory bus
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_rd,
  output logic mem_wr,
  input wire logic [7:0] mem_rdata
);

  // ************************************************************
  // state
  // ************************************************************
  branch_cmp_pkg::state_t state_reg, state_next;
  branch_cmp_pkg::cmd_t cmd_reg, cmd_next;
  logic [15:0] pc_reg, pc_next;
  logic [15:0] sp_reg, sp_next;
  logic [7:0] acc_a_reg, acc_a_next;
  logic [7:0] acc_b_reg, acc_b_next;
  logic [15:0] idx_reg, idx_next;
  logic [7:0] cc_reg, cc_next;
  logic [15:0] opnd_reg, opnd_next;
  logic left_reg, left_next;
  logic [15:0] mem_addr_reg, mem_addr_next;
  logic [7:0] mem_wdata_reg, mem_wdata_next;
  logic mem_rd_reg, mem_rd_next;
  logic mem_wr_reg, mem_wr_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [15:0] sw_rdata_reg, sw_rdata_next;

  // ************************************************************
  // branch decision and arithmetic helpers
  // ************************************************************
  logic is_branch, in_branch, br_taken;
  logic [15:0] br_offset, br_target, br_dest;
  logic [15:0] cmp_lhs, cmp_rhs, cmp_res;
  logic cmp_borrow, cmp_ovf;
  logic [16:0] cmp_sum;
  logic [7:0] unary_src, com_res;

  function automatic logic is_br_op(input branch_cmp_pkg::op_t op);
    is_br_op = (op <= branch_cmp_pkg::branch_to_subroutine);
  endfunction : is_br_op

  always_comb begin
    logic n, z, v, c;
    n = cc_reg[branch_cmp_pkg::CC_N];
    z = cc_reg[branch_cmp_pkg::CC_Z];
    v = cc_reg[branch_cmp_pkg::CC_V];
    c = cc_reg[branch_cmp_pkg::CC_C];
    in_branch = is_br_op(cmd_reg.op);
    is_branch = is_br_op(cmd_in.op);
    br_taken = 1'b0;
    unique case (cmd_reg.op)
      branch_cmp_pkg::branch_lower_or_same: br_taken = c | z;
      branch_cmp_pkg::branch_signed_less: br_taken = n ^ v;
      branch_cmp_pkg::branch_minus: br_taken = n;
      branch_cmp_pkg::branch_not_equal: br_taken = ~z;
      branch_cmp_pkg::branch_plus: br_taken = ~n;
      branch_cmp_pkg::branch_always: br_taken = 1'b1;
      branch_cmp_pkg::branch_never: br_taken = 1'b0;
      branch_cmp_pkg::branch_overflow_clear: br_taken = ~v;
      branch_cmp_pkg::branch_overflow_set: br_taken = v;
      branch_cmp_pkg::branch_to_subroutine: br_taken = 1'b1;
      default: br_taken = 1'b0;
    endcase
    // offset added to address after the whole instruction
    br_offset = cmd_reg.long_form ? opnd_reg : {{8{opnd_reg[7]}}, opnd_reg[7:0]};
    br_target = pc_reg + br_offset;
    br_dest = br_taken ? br_target : pc_reg;
    // byte compares run in the upper half so flags come out of bit 15
    unique case (cmd_reg.tgt)
      branch_cmp_pkg::tgt_acc_a: cmp_lhs = {acc_a_reg, 8'h00};
      branch_cmp_pkg::tgt_acc_b: cmp_lhs = {acc_b_reg, 8'h00};
      branch_cmp_pkg::tgt_double_acc: cmp_lhs = {acc_a_reg, acc_b_reg};
      branch_cmp_pkg::tgt_index: cmp_lhs = idx_reg;
      default: cmp_lhs = 16'h0000;
    endcase
    cmp_rhs = (cmd_reg.op == branch_cmp_pkg::compare_word) ? opnd_reg : {opnd_reg[7:0], 8'h00};
    cmp_sum = {1'b0, cmp_lhs} + {1'b0, ~cmp_rhs} + 17'h00001;
    cmp_res = cmp_sum[15:0];
    cmp_borrow = ~cmp_sum[16];
    cmp_ovf = (cmp_lhs[15] ^ cmp_rhs[15]) & (cmp_res[15] ^ cmp_lhs[15]);
    unique case (cmd_reg.tgt)
      branch_cmp_pkg::tgt_acc_a: unary_src = acc_a_reg;
      branch_cmp_pkg::tgt_acc_b: unary_src = acc_b_reg;
      default: unary_src = opnd_reg[7:0];
    endcase
    com_res = ~unary_src;
  end

  // ************************************************************
  // next-state computation
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    pc_next = pc_reg;
    sp_next = sp_reg;
    acc_a_next = acc_a_reg;
    acc_b_next = acc_b_reg;
    idx_next = idx_reg;
    cc_next = cc_reg;
    opnd_next = opnd_reg;
    left_next = left_reg;
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    mem_rd_next = 1'b0;
    mem_wr_next = 1'b0;
    busy_next = busy_reg;
    done_next = 1'b0;
    sw_rdata_next = sw_rdata_reg;
    // software access
    if (sw_rd) begin
      unique case (sw_addr)
        branch_cmp_pkg::REG_PC: sw_rdata_next = pc_reg;
        branch_cmp_pkg::REG_SP: sw_rdata_next = sp_reg;
        branch_cmp_pkg::REG_ACC_A: sw_rdata_next = {8'h00, acc_a_reg};
        branch_cmp_pkg::REG_ACC_B: sw_rdata_next = {8'h00, acc_b_reg};
        branch_cmp_pkg::REG_IDX: sw_rdata_next = idx_reg;
        branch_cmp_pkg::REG_CC: sw_rdata_next = {8'h00, cc_reg};
        branch_cmp_pkg::REG_STATUS: sw_rdata_next = {12'h000, busy_reg, state_reg};
        default: sw_rdata_next = 16'h0000;
      endcase
    end
    if (sw_wr) begin
      unique case (sw_addr)
        branch_cmp_pkg::REG_PC: pc_next = sw_wdata;
        branch_cmp_pkg::REG_SP: sp_next = sw_wdata;
        branch_cmp_pkg::REG_ACC_A: acc_a_next = sw_wdata[7:0];
        branch_cmp_pkg::REG_ACC_B: acc_b_next = sw_wdata[7:0];
        branch_cmp_pkg::REG_IDX: idx_next = sw_wdata;
        branch_cmp_pkg::REG_CC: cc_next = sw_wdata[7:0];
        default: ;
      endcase
    end
    // sequencer
    unique case (state_reg)
      branch_cmp_pkg::st_idle: begin
        if (cmd_start) begin
          cmd_next = cmd_in;
          busy_next = 1'b1;
          opnd_next = 16'h0000;
          if (is_branch) begin
            // offset bytes fetched from the instruction stream
            mem_rd_next = 1'b1;
            mem_addr_next = pc_reg;
            pc_next = pc_reg + 16'h0001;
            left_next = cmd_in.long_form;
            state_next = branch_cmp_pkg::st_wait;
          end else if (cmd_in.tgt == branch_cmp_pkg::tgt_mem ||
                       cmd_in.op == branch_cmp_pkg::compare_byte ||
                       cmd_in.op == branch_cmp_pkg::compare_word) begin
            mem_rd_next = 1'b1;
            mem_addr_next = cmd_in.effective_address;
            left_next = (cmd_in.op == branch_cmp_pkg::compare_word);
            state_next = branch_cmp_pkg::st_wait;
          end else begin
            state_next = branch_cmp_pkg::st_exec;
          end
        end
      end
      branch_cmp_pkg::st_wait: state_next = branch_cmp_pkg::st_fetch;
      branch_cmp_pkg::st_fetch: begin
        // each byte shifts in low; the first of two ends up high: big-endian operand
        opnd_next = {opnd_reg[7:0], mem_rdata};
        if (left_reg) begin
          mem_rd_next = 1'b1;
          mem_addr_next = mem_addr_reg + 16'h0001;
          if (in_branch) begin
            pc_next = pc_reg + 16'h0001;
          end
          left_next = 1'b0;
          state_next = branch_cmp_pkg::st_wait;
        end else begin
          state_next = branch_cmp_pkg::st_exec;
        end
      end
      branch_cmp_pkg::st_exec: begin
        state_next = branch_cmp_pkg::st_idle;
        busy_next = 1'b0;
        done_next = 1'b1;
        unique case (cmd_reg.op)
          branch_cmp_pkg::branch_to_subroutine: begin
            sp_next = sp_reg - 16'h0001;
            mem_addr_next = sp_reg - 16'h0001;
            mem_wdata_next = pc_reg[7:0];
            mem_wr_next = 1'b1;
            state_next = branch_cmp_pkg::st_push_hi;
            busy_next = 1'b1;
            done_next = 1'b0;
          end
          branch_cmp_pkg::clear_operand: begin
            cc_next[branch_cmp_pkg::CC_N] = 1'b0;
            cc_next[branch_cmp_pkg::CC_Z] = 1'b1;
            cc_next[branch_cmp_pkg::CC_V] = 1'b0;
            cc_next[branch_cmp_pkg::CC_C] = 1'b0;
            if (cmd_reg.tgt == branch_cmp_pkg::tgt_acc_a) begin
              acc_a_next = branch_cmp_pkg::CLEAR_VALUE;
            end else if (cmd_reg.tgt == branch_cmp_pkg::tgt_acc_b) begin
              acc_b_next = branch_cmp_pkg::CLEAR_VALUE;
            end else begin
              mem_wr_next = 1'b1;
              mem_wdata_next = branch_cmp_pkg::CLEAR_VALUE;
            end
          end
          branch_cmp_pkg::ones_complement_op: begin
            cc_next[branch_cmp_pkg::CC_N] = com_res[7];
            cc_next[branch_cmp_pkg::CC_Z] = (com_res == 8'h00);
            cc_next[branch_cmp_pkg::CC_V] = 1'b0;
            cc_next[branch_cmp_pkg::CC_C] = 1'b1;
            if (cmd_reg.tgt == branch_cmp_pkg::tgt_acc_a) begin
              acc_a_next = com_res;
            end else if (cmd_reg.tgt == branch_cmp_pkg::tgt_acc_b) begin
              acc_b_next = com_res;
            end else begin
              mem_wr_next = 1'b1;
              mem_wdata_next = com_res;
            end
          end
          branch_cmp_pkg::compare_byte, branch_cmp_pkg::compare_word: begin
            // half-carry left as it was; no write-back
            cc_next[branch_cmp_pkg::CC_N] = cmp_res[15];
            cc_next[branch_cmp_pkg::CC_Z] = (cmp_res == 16'h0000);
            cc_next[branch_cmp_pkg::CC_V] = cmp_ovf;
            cc_next[branch_cmp_pkg::CC_C] = cmp_borrow;
            if (cmd_reg.op == branch_cmp_pkg::compare_word) begin
              idx_next = idx_reg + {{13{cmd_reg.idx_step[2]}}, cmd_reg.idx_step};
            end
          end
          default: begin
            pc_next = br_dest;
          end
        endcase
      end
      branch_cmp_pkg::st_push_hi: begin
        sp_next = sp_reg - 16'h0001;
        mem_addr_next = sp_reg - 16'h0001;
        mem_wdata_next = pc_reg[15:8];
        mem_wr_next = 1'b1;
        state_next = branch_cmp_pkg::st_jump;
      end
      branch_cmp_pkg::st_jump: begin
        pc_next = br_target;
        state_next = branch_cmp_pkg::st_idle;
        busy_next = 1'b0;
        done_next = 1'b1;
      end
      default: begin
        state_next = branch_cmp_pkg::st_idle;
        busy_next = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= branch_cmp_pkg::st_idle;
      cmd_reg <= '0;
      pc_reg <= branch_cmp_pkg::PC_RESET;
      sp_reg <= branch_cmp_pkg::SP_RESET;
      acc_a_reg <= 8'h00;
      acc_b_reg <= 8'h00;
      idx_reg <= 16'h0000;
      cc_reg <= branch_cmp_pkg::CC_RESET;
      opnd_reg <= 16'h0000;
      left_reg <= 1'b0;
      mem_addr_reg <= 16'h0000;
      mem_wdata_reg <= 8'h00;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      sw_rdata_reg <= 16'h0000;
    end else if (ce) begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      pc_reg <= pc_next;
      sp_reg <= sp_next;
      acc_a_reg <= acc_a_next;
      acc_b_reg <= acc_b_next;
      idx_reg <= idx_next;
      cc_reg <= cc_next;
      opnd_reg <= opnd_next;
      left_reg <= left_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      mem_rd_reg <= mem_rd_next;
      mem_wr_reg <= mem_wr_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      sw_rdata_reg <= sw_rdata_next;
    end
  end

  assign sw_rdata = sw_rdata_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign mem_rd = mem_rd_reg;
  assign mem_wr = mem_wr_reg;

  // ************************************************************
  // checks
  // ************************************************************
  logic in_exec;
  assign in_exec = ce && (state_reg == branch_cmp_pkg::st_exec);

  lower_same_a: assert property (@(posedge mclk) disable iff (!rst_n)
    in_exec && cmd_reg.op == branch_cmp_pkg::branch_lower_or_same
    |-> br_taken == (cc_reg[branch_cmp_pkg::CC_C] | cc_reg[branch_cmp_pkg::CC_Z]))
    else $error("lower-or-same decision wrong");
  signed_less_a: assert property (@(posedge mclk) disable iff (!rst_n)
    in_exec && cmd_reg.op == branch_cmp_pkg::branch_signed_less
    |-> br_taken == (cc_reg[branch_cmp_pkg::CC_N] ^ cc_reg[branch_cmp_pkg::CC_V]))
    else $error("signed-less decision wrong");
  minus_plus_a: assert property (@(posedge mclk) disable iff (!rst_n)
    in_exec && (cmd_reg.op == branch_cmp_pkg::branch_minus ||
                cmd_reg.op == branch_cmp_pkg::branch_plus)
    |-> br_taken == (cc_reg[branch_cmp_pkg::CC_N] ^
                     (cmd_reg.op == branch_cmp_pkg::branch_plus)))
    else $error("sign branch decision wrong");
  not_equal_a: assert property (@(posedge mclk) disable iff (!rst_n)
    in_exec && cmd_reg.op == branch_cmp_pkg::branch_not_equal
    |-> br_taken != cc_reg[branch_cmp_pkg::CC_Z])
    else $error("not-equal decision wrong");
  overflow_br_a: assert property (@(posedge mclk) disable iff (!rst_n)
    in_exec && (cmd_reg.op == branch_cmp_pkg::branch_overflow_set ||
                cmd_reg.op == branch_cmp_pkg::branch_overflow_clear)
    |-> br_taken == (cc_reg[branch_cmp_pkg::CC_V] ^
                     (cmd_reg.op == branch_cmp_pkg::branch_overflow_clear)))
    else $error("overflow branch decision wrong");
  branch_pc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    in_exec && in_branch && cmd_reg.op != branch_cmp_pkg::branch_to_subroutine && !sw_wr
    |=> pc_reg == $past(br_dest) && done_reg)
    else $error("branch counter update wrong");
  subr_push_a: assert property (@(posedge mclk) disable iff (!rst_n)
    in_exec && cmd_reg.op == branch_cmp_pkg::branch_to_subroutine && !sw_wr
    ##1 ce[*2]
    |-> mem_wr_reg && mem_wdata_reg == pc_reg[15:8] && mem_addr_reg == sp_reg
        && $past(mem_wr_reg) && $past(mem_addr_reg) == sp_reg + 16'h0001)
    else $error("subroutine stacking order wrong");
  flags_kept_a: assert property (@(posedge mclk) disable iff (!rst_n)
    busy_reg && in_branch && !sw_wr |=> $stable(cc_reg))
    else $error("branch altered flags");
  clear_flags_a: assert property (@(posedge mclk) disable iff (!rst_n)
    in_exec && cmd_reg.op == branch_cmp_pkg::clear_operand && !sw_wr
    |=> cc_reg[3:0] == 4'h4 && $stable(cc_reg[branch_cmp_pkg::CC_H]))
    else $error("clear flags wrong");
  cmp_borrow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    in_exec && cmd_reg.op == branch_cmp_pkg::compare_byte && !sw_wr
    |=> cc_reg[branch_cmp_pkg::CC_C] == ($past(cmp_lhs[15:8]) < $past(opnd_reg[7:0])))
    else $error("compare borrow wrong");
  com_flags_a: assert property (@(posedge mclk) disable iff (!rst_n)
    in_exec && cmd_reg.op == branch_cmp_pkg::ones_complement_op && !sw_wr
    |=> cc_reg[branch_cmp_pkg::CC_C] && !cc_reg[branch_cmp_pkg::CC_V])
    else $error("complement flags wrong");

endmodule : branch_compare_flag_unit
`default_nettype wire

// ---- test/branch_compare_flag_unit_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module branch_compare_flag_unit_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic cmd_start = 1'b0;
  branch_cmp_pkg::cmd_t cmd_in = '0;
  logic busy;
  logic done;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] mem [0:65535];
  logic [15:0] last_rd = 16'h0000;
  logic [15:0] wr_after_rd = 16'h0000;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;

  branch_compare_flag_unit u_dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .cmd_start(cmd_start),
    .cmd_in(cmd_in), .busy(busy), .done(done), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata)
  );

  always #2.5 mclk = ~mclk;

  // ************************************************************
  // memory model and run limit
  // ************************************************************
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (mem_rd === 1'b1) begin
      mem_rdata <= mem[mem_addr];
      last_rd <= mem_addr;
    end else begin
      // released bus inverts the last byte every cycle
      mem_rdata <= ~mem_rdata;
    end
    if (mem_wr === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
      wr_after_rd <= last_rd;
    end
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask : sw_write

  task automatic expect_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge mclk);
    sw_rd <= 1'b0;
    @(posedge mclk);
    check(sw_rdata, exp);
  endtask : expect_reg

  task automatic run_cmd(input int op, input logic lf, input int tgt, input logic [15:0] ea,
                         input logic signed [2:0] step);
    int n;
    n = 0;
    @(posedge mclk);
    cmd_start <= 1'b1;
    cmd_in <= '{branch_cmp_pkg::op_t'(op), lf, branch_cmp_pkg::tgt_t'(tgt), ea, step};
    @(posedge mclk);
    cmd_start <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (done !== 1'b1 && n < 40);
    check({15'h0000, done}, 16'h0001);
  endtask : run_cmd

  function automatic logic taken(input int op, input logic [7:0] f);
    case (op)
      0: return f[0] | f[2];
      1: return f[3] ^ f[1];
      2: return f[3];
      3: return !f[2];
      4: return !f[3];
      5: return 1'b1;
      7: return !f[1];
      8: return f[1];
      default: return 1'b0;
    endcase
  endfunction : taken

  // n z v c of register minus memory
  function automatic logic [3:0] cmp_flags(input logic [15:0] a, input logic [15:0] m,
                                           input logic wide);
    logic [16:0] r;
    logic sa;
    logic sm;
    r = wide ? {1'b0, a} - {1'b0, m} : {9'h000, a[7:0]} - {9'h000, m[7:0]};
    sa = wide ? a[15] : a[7];
    sm = wide ? m[15] : m[7];
    if (wide) begin
      return {r[15], r[15:0] == 16'h0000, sa != sm && r[15] != sa, r[16]};
    end
    return {r[7], r[7:0] == 8'h00, sa != sm && r[7] != sa, r[8]};
  endfunction : cmp_flags

  task automatic unary(input int op, input int tgt, input logic [7:0] v, input logic [7:0] c,
                       input logic [7:0] ev, input logic [7:0] ec);
    logic [3:0] a;
    a = (tgt == 1) ? branch_cmp_pkg::REG_ACC_B : branch_cmp_pkg::REG_ACC_A;
    mem[16'h0400] = v;
    if (tgt != 2) sw_write(a, {8'h00, v});
    sw_write(branch_cmp_pkg::REG_CC, {8'h00, c});
    run_cmd(op, 1'b0, tgt, 16'h0400, 3'sd0);
    expect_reg(branch_cmp_pkg::REG_CC, {8'h00, ec});
    if (tgt == 2) check({8'h00, mem[16'h0400]}, {8'h00, ev});
    else expect_reg(a, {8'h00, ev});
  endtask : unary

  task automatic compare(input int op, input int tgt, input logic [15:0] r,
                         input logic [15:0] m, input logic [7:0] c, input logic signed [2:0] st);
    logic [3:0] a;
    a = (tgt == 0) ? branch_cmp_pkg::REG_ACC_A :
        (tgt == 1) ? branch_cmp_pkg::REG_ACC_B : branch_cmp_pkg::REG_IDX;
    mem[16'h0500] = (op == 12) ? m[15:8] : m[7:0];
    mem[16'h0501] = m[7:0];
    if (tgt == 3) begin
      sw_write(branch_cmp_pkg::REG_ACC_A, {8'h00, r[15:8]});
      sw_write(branch_cmp_pkg::REG_ACC_B, {8'h00, r[7:0]});
    end else begin
      sw_write(a, r);
    end
    sw_write(branch_cmp_pkg::REG_CC, {8'h00, c});
    run_cmd(op, 1'b0, tgt, 16'h0500, st);
    expect_reg(branch_cmp_pkg::REG_CC, {8'h00, c[7:4], cmp_flags(r, m, op == 12)});
    if (tgt == 3) begin
      expect_reg(branch_cmp_pkg::REG_ACC_A, {8'h00, r[15:8]});
      expect_reg(branch_cmp_pkg::REG_ACC_B, {8'h00, r[7:0]});
    end else begin
      expect_reg(a, r + {{13{st[2]}}, st});
    end
    check({8'h00, mem[16'h0500]}, {8'h00, (op == 12) ? m[15:8] : m[7:0]});
  endtask : compare

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    logic [7:0] off;
    logic [7:0] cv;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) expect_reg(4'(i), 16'h0000);
    sw_write(4'h7, 16'hFFFF);
    sw_write(branch_cmp_pkg::REG_STATUS, 16'hFFFF);
    expect_reg(4'h7, 16'h0000);
    expect_reg(branch_cmp_pkg::REG_STATUS, 16'h0000);
    $display("test reset_and_map done");
    for (int op = 0; op < 9; op++) begin
      for (int f = 0; f < 16; f++) begin
        cv = {4'h2, 4'(f)};
        off = f[0] ? 8'hF0 : 8'h10;
        mem[16'h0100] = off;
        sw_write(branch_cmp_pkg::REG_CC, {8'h00, cv});
        sw_write(branch_cmp_pkg::REG_PC, 16'h0100);
        run_cmd(op, 1'b0, 0, 16'h0000, 3'sd0);
        expect_reg(branch_cmp_pkg::REG_PC,
                   taken(op, cv) ? 16'h0101 + {{8{off[7]}}, off} : 16'h0101);
        expect_reg(branch_cmp_pkg::REG_CC, {8'h00, cv});
      end
    end
    for (int k = 0; k < 2; k++) begin
      mem[16'h0100] = 8'h12;
      mem[16'h0101] = 8'h34;
      sw_write(branch_cmp_pkg::REG_PC, 16'h0100);
      sw_write(branch_cmp_pkg::REG_CC, 16'h000F);
      run_cmd(k ? 6 : 5, 1'b1, 0, 16'h0000, 3'sd0);
      expect_reg(branch_cmp_pkg::REG_PC, k ? 16'h0102 : 16'h1336);
      expect_reg(branch_cmp_pkg::REG_CC, 16'h000F);
    end
    $display("test branches done");
    for (int lf = 0; lf < 2; lf++) begin
      mem[16'h0300] = 8'hFF;
      mem[16'h0301] = 8'hFE;
      sw_write(branch_cmp_pkg::REG_SP, 16'h0200);
      sw_write(branch_cmp_pkg::REG_PC, 16'h0300);
      sw_write(branch_cmp_pkg::REG_CC, 16'h002F);
      run_cmd(9, lf[0], 0, 16'h0000, 3'sd0);
      expect_reg(branch_cmp_pkg::REG_PC, 16'h0300);
      expect_reg(branch_cmp_pkg::REG_SP, 16'h01FE);
      expect_reg(branch_cmp_pkg::REG_CC, 16'h002F);
      check({8'h00, mem[16'h01FF]}, lf ? 16'h0002 : 16'h0001);
      check({8'h00, mem[16'h01FE]}, 16'h0003);
    end
    $display("test subroutine done");
    unary(10, 0, 8'h77, 8'h2B, 8'h00, 8'h24);
    unary(10, 2, 8'h5A, 8'h2B, 8'h00, 8'h24);
    check(wr_after_rd, 16'h0400);
    unary(13, 1, 8'h00, 8'h02, 8'hFF, 8'h09);
    unary(13, 2, 8'hFF, 8'h2A, 8'h00, 8'h25);
    $display("test clear_complement done");
    compare(11, 0, 16'h0050, 16'h0050, 8'h20, 3'sd0);
    compare(11, 1, 16'h0010, 16'h0020, 8'h2F, 3'sd0);
    compare(11, 0, 16'h0080, 16'h0001, 8'h00, 3'sd0);
    compare(11, 1, 16'h007F, 16'h00FF, 8'h20, 3'sd0);
    compare(12, 3, 16'h1234, 16'h1235, 8'h20, 3'sd0);
    compare(12, 4, 16'h8000, 16'h0001, 8'h2F, 3'sd2);
    compare(12, 4, 16'h0005, 16'h0005, 8'h00, -3'sd1);
    $display("test compare done");
    finish_test();
  end
endmodule : branch_compare_flag_unit_tb
`default_nettype wire
